/* File: phymb_pkg.sv */
// constants, field positions and types of the phy management register bank
// assumes a 200 MHz system clock and a two-wire management bus slave
package phymb_pkg;

   // bus addressing
   localparam logic [6:0] DEV_ADDR = 7'h57;
   localparam logic [4:0] REG_CONTROL = 5'h00;
   localparam logic [4:0] REG_STATUS = 5'h01;
   localparam logic [4:0] REG_ADVERT = 5'h04;

   // control field positions
   localparam int CTL_RESET = 15;
   localparam int CTL_LOOP = 14;
   localparam int CTL_SPD_LSB = 13;
   localparam int CTL_AN_EN = 12;
   localparam int CTL_PDOWN = 11;
   localparam int CTL_ISO = 10;
   localparam int CTL_AN_RESTART = 9;
   localparam int CTL_DUPLEX = 8;
   localparam int CTL_COL_TEST = 7;
   localparam int CTL_SPD_MSB = 6;

   // status field positions
   localparam int STS_EXT_STATUS = 8;
   localparam int STS_NO_PREAMBLE = 6;
   localparam int STS_AN_DONE = 5;
   localparam int STS_REM_FAULT = 4;
   localparam int STS_AN_ABLE = 3;
   localparam int STS_LINK = 2;
   localparam int STS_JABBER = 1;
   localparam int STS_EXT_CAP = 0;

   // advertisement field positions
   localparam int ADV_RF = 13;
   localparam int ADV_PAUSE_LO = 10;
   localparam int ADV_SPARE9 = 9;
   localparam int ADV_STORE_LO = 5;

   // reset values
   localparam logic [1:0] SPEED_1000 = 2'h2;
   localparam logic [1:0] ADV_TOP_RESET = 2'h2;
   localparam logic [1:0] PAUSE_NONE = 2'h0;
   localparam logic [4:0] ADV_SELECTOR = 5'h01;

   // software reset duration
   localparam int CLK_PERIOD_NS = 5;
   localparam int SWRST_TIME_NS = 1000;
   localparam int SWRST_CYCLES = (SWRST_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SWRST_CNT_W = 8;

   typedef enum logic [8:0] {
      ST_IDLE     = 9'h001,
      ST_ADDR     = 9'h002,
      ST_ACK_ADDR = 9'h004,
      ST_REGPTR   = 9'h008,
      ST_ACK_REG  = 9'h010,
      ST_WR_DATA  = 9'h020,
      ST_ACK_WR   = 9'h040,
      ST_RD_DATA  = 9'h080,
      ST_RD_ACK   = 9'h100
   } phymb_state_t;

endpackage : phymb_pkg

/* File: phymb_twi_if.sv */
// bus events passed from the pin front end to the frame engine
// assumes both ends run on the same system clock
`timescale 1ns/1ps
`default_nettype none
interface phymb_twi_if;
   logic scl_rise;
   logic scl_fall;
   logic sda_lvl;
   logic start_det;
   logic stop_det;
   modport front (output scl_rise, output scl_fall, output sda_lvl,
                  output start_det, output stop_det);
   modport frame (input scl_rise, input scl_fall, input sda_lvl,
                  input start_det, input stop_det);
endinterface : phymb_twi_if
`default_nettype wire

/* File: phymb_twi_front.sv */
// pin front end: synchronises the bus pins and finds edges, start and stop
// assumes scl and sda arrive asynchronously from the host
`timescale 1ns/1ps
`default_nettype none
module phymb_twi_front
   import phymb_pkg::*;
(
   // clock and reset
   input wire logic clock,
   input wire logic rst,
   // pins
   input wire logic scl_in,
   input wire logic sda_in,
   // events
   phymb_twi_if.front ev
);
   typedef struct packed {
      logic scl1;
      logic sda1;
      logic scl2;
      logic sda2;
      logic scl3;
      logic sda3;
   } phymb_sync_t;

   phymb_sync_t s;
   phymb_sync_t next_s;

   always_comb begin
      next_s = s;
      next_s.scl1 = scl_in;
      next_s.sda1 = sda_in;
      next_s.scl2 = s.scl1;
      next_s.sda2 = s.sda1;
      next_s.scl3 = s.scl2;
      next_s.sda3 = s.sda2;
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         s <= 6'h3f;
      end else begin
         s <= next_s;
      end
   end

   // a start needs no idle preamble before it
   assign ev.start_det = s.scl2 & s.scl3 & s.sda3 & ~s.sda2;
   assign ev.stop_det = s.scl2 & s.scl3 & ~s.sda3 & s.sda2;
   assign ev.scl_rise = s.scl2 & ~s.scl3;
   assign ev.scl_fall = ~s.scl2 & s.scl3;
   assign ev.sda_lvl = s.sda2;
endmodule : phymb_twi_front
`default_nettype wire

/* File: phymb_register_bank.sv */
// management register bank: control, status and advertisement over a
// two-wire bus slave, with the control outputs that steer the phy core
// assumes phy core status inputs and data bits are on the system clock
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - loopback returns receive data onto transmit pair
// - forced speed from bits 6 and 13
// - speed bits act only with negotiation off
// - negotiation enable applies when software reset starts
// - duplex bit, full when one, forced mode
// - collision test bit drives collision indication
// - status bit 8 reads one
// - status bit 6 one, preamble not needed
// - status bit 5 shows negotiation complete
// - remote fault latches high until read
// - jabber latches high, link latches low
// - status bit 3 reads one
// - status bit 0 one, others zero
// - fault and pause apply on restart or link-down
// - pause field encoding, resets to 00
// - speed abilities model reset, apply on restart
// - selector field fixed at 00001
// - device address, register byte, 16-bit transfers
module phymb_register_bank
   import phymb_pkg::*;
#(
   parameter logic [3:0] ADV_ABILITY_RESET = 4'hf
)(
   // clock and reset
   input wire logic clock,
   input wire logic rst,
   // management bus pins
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   // phy core status
   input wire logic link_up,
   input wire logic remote_fault,
   input wire logic jabber,
   input wire logic an_complete,
   // phy core datapath
   input wire logic rx_bit,
   input wire logic tx_bit,
   input wire logic tx_en,
   input wire logic col_in,
   output logic serial_tx_pair,
   output logic col_ind,
   // phy core control
   output logic soft_reset,
   output logic power_down,
   output logic isolate,
   output logic loopback,
   output logic col_test,
   output logic an_enable,
   output logic an_restart,
   output logic [1:0] force_speed,
   output logic force_duplex,
   output logic [15:0] adv_word
);
   if (SWRST_CYCLES < 1 || SWRST_CYCLES > 255) begin : g_chk
      $error("software reset count does not fit its counter");
   end

   typedef struct packed {
      phymb_state_t st;
      logic [3:0] bitcnt;
      logic [7:0] shreg;
      logic rw;
      logic [4:0] regptr;
      logic [7:0] wbuf;
      logic byte_lo;
      logic [15:0] txb;
      logic drive;
      logic swrst;
      logic [SWRST_CNT_W-1:0] swcnt;
      logic loop_en;
      logic spd_lsb;
      logic an_en;
      logic an_act;
      logic pdown;
      logic iso;
      logic restart;
      logic duplex;
      logic coltest;
      logic spd_msb;
      logic [10:0] adv;
      logic [15:0] adv_act;
      logic lat_rf;
      logic lat_jab;
      logic lat_link;
      logic link_q;
      logic tx_q;
      logic col_q;
   } phymb_regs_t;

   localparam logic [10:0] ADV_RESET = {ADV_TOP_RESET, 1'b0, 1'b0, PAUSE_NONE, 1'b0,
                                        ADV_ABILITY_RESET};

   localparam phymb_regs_t REGS_RESET = '{
      st: ST_IDLE, bitcnt: 4'h0, shreg: 8'h00, rw: 1'b0, regptr: 5'h00,
      wbuf: 8'h00, byte_lo: 1'b0, txb: 16'h0000, drive: 1'b0,
      swrst: 1'b0, swcnt: 8'h00, loop_en: 1'b0,
      spd_lsb: SPEED_1000[0], an_en: 1'b1, an_act: 1'b1,
      pdown: 1'b0, iso: 1'b0, restart: 1'b0, duplex: 1'b1, coltest: 1'b0,
      spd_msb: SPEED_1000[1], adv: ADV_RESET,
      adv_act: {ADV_RESET, ADV_SELECTOR},
      lat_rf: 1'b0, lat_jab: 1'b0, lat_link: 1'b0, link_q: 1'b0,
      tx_q: 1'b0, col_q: 1'b0
   };

   phymb_regs_t s;
   phymb_regs_t next_s;

   phymb_twi_if tw ();

   phymb_twi_front u_front (
      .clock (clock),
      .rst (rst),
      .scl_in (scl_in),
      .sda_in (sda_in),
      .ev (tw.front)
   );

   // word seen by the host for a register number
   function automatic logic [15:0] read_reg(input logic [4:0] ptr, input phymb_regs_t r);
      logic [15:0] w;
      w = 16'h0000;
      case (ptr)
         REG_CONTROL: begin
            w[CTL_RESET] = r.swrst;
            w[CTL_LOOP] = r.loop_en;
            w[CTL_SPD_LSB] = r.spd_lsb;
            w[CTL_AN_EN] = r.an_en;
            w[CTL_PDOWN] = r.pdown;
            w[CTL_ISO] = r.iso;
            w[CTL_AN_RESTART] = r.restart;
            w[CTL_DUPLEX] = r.duplex;
            w[CTL_COL_TEST] = r.coltest;
            w[CTL_SPD_MSB] = r.spd_msb;
         end
         REG_STATUS: begin
            w[STS_EXT_STATUS] = 1'b1;
            w[STS_NO_PREAMBLE] = 1'b1;
            w[STS_AN_DONE] = an_complete;
            w[STS_REM_FAULT] = r.lat_rf;
            w[STS_AN_ABLE] = 1'b1;
            w[STS_LINK] = r.lat_link;
            w[STS_JABBER] = r.lat_jab;
            w[STS_EXT_CAP] = 1'b1;
         end
         REG_ADVERT: begin
            w = {r.adv, ADV_SELECTOR};
         end
         default: begin
            w = 16'h0000;
         end
      endcase
      return w;
   endfunction : read_reg

   always_comb begin
      logic [7:0] byte_in;
      logic [15:0] wword;
      logic [15:0] rword;
      logic commit;
      logic clr_lat;
      byte_in = {s.shreg[6:0], tw.sda_lvl};
      wword = {s.wbuf, byte_in};
      rword = 16'h0000;
      commit = 1'b0;
      clr_lat = 1'b0;
      next_s = s;
      next_s.restart = 1'b0;

      // bus frame engine
      if (tw.start_det) begin
         next_s.st = ST_ADDR;
         next_s.bitcnt = 4'h0;
         next_s.drive = 1'b0;
      end else if (tw.stop_det) begin
         next_s.st = ST_IDLE;
         next_s.drive = 1'b0;
      end else begin
         case (s.st)
            ST_ADDR, ST_REGPTR, ST_WR_DATA: begin
               if (tw.scl_rise) begin
                  next_s.shreg = byte_in;
                  next_s.bitcnt = s.bitcnt + 4'h1;
                  if (s.bitcnt == 4'h7) begin
                     if (s.st == ST_ADDR) begin
                        next_s.rw = byte_in[0];
                        next_s.st = (byte_in[7:1] == DEV_ADDR) ? ST_ACK_ADDR : ST_IDLE;
                     end else if (s.st == ST_REGPTR) begin
                        next_s.regptr = byte_in[4:0];
                        next_s.st = ST_ACK_REG;
                     end else begin
                        next_s.st = ST_ACK_WR;
                        next_s.byte_lo = ~s.byte_lo;
                        if (!s.byte_lo) begin
                           next_s.wbuf = byte_in;
                        end else begin
                           commit = 1'b1;
                           next_s.regptr = s.regptr + 5'h1;
                        end
                     end
                  end
               end
            end
            ST_ACK_ADDR, ST_ACK_REG, ST_ACK_WR: begin
               if (tw.scl_fall) begin
                  if (!s.drive) begin
                     next_s.drive = 1'b1;
                  end else begin
                     next_s.drive = 1'b0;
                     next_s.bitcnt = 4'h0;
                     if (s.st == ST_ACK_ADDR && s.rw) begin
                        rword = read_reg(s.regptr, s);
                        clr_lat = (s.regptr == REG_STATUS);
                        next_s.txb = rword;
                        next_s.byte_lo = 1'b0;
                        next_s.drive = ~rword[15];
                        next_s.st = ST_RD_DATA;
                     end else if (s.st == ST_ACK_ADDR) begin
                        next_s.byte_lo = 1'b0;
                        next_s.st = ST_REGPTR;
                     end else begin
                        next_s.st = ST_WR_DATA;
                     end
                  end
               end
            end
            ST_RD_DATA: begin
               if (tw.scl_rise) begin
                  next_s.bitcnt = s.bitcnt + 4'h1;
                  if (s.bitcnt == 4'h7) begin
                     next_s.st = ST_RD_ACK;
                  end
               end else if (tw.scl_fall) begin
                  next_s.txb = {s.txb[14:0], 1'b0};
                  next_s.drive = ~s.txb[14];
               end
            end
            ST_RD_ACK: begin
               if (tw.scl_fall && s.bitcnt == 4'h8) begin
                  next_s.drive = 1'b0;
                  next_s.txb = {s.txb[14:0], 1'b0};
                  next_s.bitcnt = 4'h9;
               end else if (tw.scl_rise && s.bitcnt == 4'h9) begin
                  if (tw.sda_lvl) begin
                     next_s.st = ST_IDLE;
                  end else begin
                     next_s.bitcnt = 4'ha;
                  end
               end else if (tw.scl_fall && s.bitcnt == 4'ha) begin
                  next_s.st = ST_RD_DATA;
                  next_s.bitcnt = 4'h0;
                  if (!s.byte_lo) begin
                     next_s.byte_lo = 1'b1;
                     next_s.drive = ~s.txb[15];
                  end else begin
                     rword = read_reg(s.regptr + 5'h1, s);
                     clr_lat = (s.regptr + 5'h1 == REG_STATUS);
                     next_s.regptr = s.regptr + 5'h1;
                     next_s.txb = rword;
                     next_s.byte_lo = 1'b0;
                     next_s.drive = ~rword[15];
                  end
               end
            end
            default: begin
               next_s.drive = 1'b0;
            end
         endcase
      end

      // software reset countdown
      if (s.swrst) begin
         if (s.swcnt == '0) begin
            next_s.swrst = 1'b0;
         end else begin
            next_s.swcnt = s.swcnt - 1'b1;
         end
      end

      // register writes
      if (commit && s.regptr == REG_CONTROL) begin
         next_s.loop_en = wword[CTL_LOOP];
         next_s.spd_lsb = wword[CTL_SPD_LSB];
         next_s.spd_msb = wword[CTL_SPD_MSB];
         next_s.an_en = wword[CTL_AN_EN];
         next_s.pdown = wword[CTL_PDOWN];
         next_s.iso = wword[CTL_ISO];
         next_s.restart = wword[CTL_AN_RESTART];
         next_s.duplex = wword[CTL_DUPLEX];
         next_s.coltest = wword[CTL_COL_TEST];
         if (wword[CTL_RESET]) begin
            next_s.swrst = 1'b1;
            next_s.swcnt = SWRST_CNT_W'(SWRST_CYCLES - 1);
            next_s.an_act = wword[CTL_AN_EN];
            next_s.loop_en = 1'b0;
            next_s.pdown = 1'b0;
            next_s.iso = 1'b0;
            next_s.restart = 1'b0;
            next_s.coltest = 1'b0;
            next_s.adv[ADV_SPARE9 - ADV_STORE_LO] = 1'b0;
         end
      end else if (commit && s.regptr == REG_ADVERT) begin
         next_s.adv = wword[15:ADV_STORE_LO];
      end

      // advertised word reaches the negotiation logic on restart; bits 13 to 10 (fault and pause) also on link drop
      if (s.restart) begin
         next_s.adv_act = {s.adv, ADV_SELECTOR};
      end else if (s.link_q && !link_up) begin
         next_s.adv_act[ADV_RF:ADV_PAUSE_LO] = s.adv[ADV_RF - ADV_STORE_LO:
                                                     ADV_PAUSE_LO - ADV_STORE_LO];
      end

      // status latches: a new event wins over the read that clears
      next_s.lat_rf = remote_fault | (s.lat_rf & ~clr_lat);
      next_s.lat_jab = jabber | (s.lat_jab & ~clr_lat);
      next_s.lat_link = link_up & (s.lat_link | clr_lat);
      next_s.link_q = link_up;

      // datapath hooks
      next_s.tx_q = s.pdown ? 1'b0 : (s.loop_en ? rx_bit : tx_bit);
      next_s.col_q = col_in | (s.coltest & tx_en);
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         s <= REGS_RESET;
      end else begin
         s <= next_s;
      end
   end

   assign sda_out = 1'b0;
   assign sda_oe = s.drive;
   assign serial_tx_pair = s.tx_q;
   assign col_ind = s.col_q;
   assign soft_reset = s.swrst;
   assign power_down = s.pdown;
   assign isolate = s.iso;
   assign loopback = s.loop_en;
   assign col_test = s.coltest;
   assign an_enable = s.an_act;
   assign an_restart = s.restart;
   assign force_speed = s.an_act ? SPEED_1000 : {s.spd_msb, s.spd_lsb};
   assign force_duplex = s.an_act ? 1'b1 : s.duplex;
   assign adv_word = s.adv_act;
endmodule : phymb_register_bank
`default_nettype wire

/* File: phymb_chk.sv */
// assertions on the ports of the phy management register bank
// assumes one clock domain and the asynchronous active-high reset
`timescale 1ns/1ps
`default_nettype none
module phymb_chk
   import phymb_pkg::*;
(
   // clock and reset
   input wire logic clock,
   input wire logic rst,
   // observed ports
   input wire logic sda_out,
   input wire logic link_up,
   input wire logic rx_bit,
   input wire logic tx_en,
   input wire logic col_ind,
   input wire logic serial_tx_pair,
   input wire logic soft_reset,
   input wire logic power_down,
   input wire logic isolate,
   input wire logic loopback,
   input wire logic col_test,
   input wire logic an_enable,
   input wire logic an_restart,
   input wire logic [1:0] force_speed,
   input wire logic force_duplex,
   input wire logic [15:0] adv_word
);
   // cycles spent in software reset so far
   logic [8:0] sr_cnt;
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         sr_cnt <= 9'h000;
      end else begin
         sr_cnt <= soft_reset ? sr_cnt + 9'h001 : 9'h000;
      end
   end
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (rst);
   AST_SWRST_LEN: assert property ($fell(soft_reset) |-> sr_cnt == 9'(SWRST_CYCLES))
      else $error("software reset length wrong");
   AST_SWRST_CLEAR: assert property ($fell(soft_reset) |-> !loopback && !col_test
      && !power_down && !isolate) else $error("control bits not cleared by soft reset");
   AST_AN_EN_HOLD: assert property ($changed(an_enable) |-> soft_reset || $past(soft_reset))
      else $error("negotiation enable changed outside soft reset");
   AST_SPEED_AN: assert property (an_enable |-> force_speed == 2'h2 && force_duplex)
      else $error("forced speed or duplex active with negotiation on");
   AST_RESTART_PULSE: assert property (an_restart |=> !an_restart)
      else $error("restart pulse longer than one cycle");
   AST_ADV_APPLY: assert property ($changed(adv_word) |-> an_restart || $past(an_restart)
      || !link_up || !$past(link_up) || soft_reset || $past(soft_reset))
      else $error("advertisement applied without restart or link drop");
   AST_ADV_SELECTOR: assert property (adv_word[4:0] == ADV_SELECTOR)
      else $error("selector field not fixed");
   AST_LOOPBACK: assert property (loopback && !power_down |=> serial_tx_pair == $past(rx_bit))
      else $error("loopback data not returned");
   AST_COL_TEST: assert property (col_test && tx_en |=> col_ind)
      else $error("collision test not shown");
   AST_SDA_OPEN: assert property (sda_out == 1'b0)
      else $error("data pin driven high");
endmodule : phymb_chk
bind phymb_register_bank phymb_chk i_phymb_chk (.clock(clock), .rst(rst), .sda_out(sda_out),
   .link_up(link_up), .rx_bit(rx_bit), .tx_en(tx_en), .col_ind(col_ind),
   .serial_tx_pair(serial_tx_pair), .soft_reset(soft_reset), .power_down(power_down),
   .isolate(isolate), .loopback(loopback), .col_test(col_test), .an_enable(an_enable),
   .an_restart(an_restart), .force_speed(force_speed), .force_duplex(force_duplex),
   .adv_word(adv_word));
`default_nettype wire

/* File: phymb_host_model.sv */
// host controller model on the two-wire management bus
// assumes the bench resolves the open-drain data wire with a pull-up
`timescale 1ns/1ps
`default_nettype none
module phymb_host_model (
   // clock
   input wire logic clock,
   // bus
   input wire logic sda_wire,
   output logic scl,
   output logic sda_low
);
   initial begin
      scl = 1'b1;
      sda_low = 1'b0;
   end
   task automatic hold(input int n);
      repeat (n) @(negedge clock);
   endtask : hold
   // one bit slot: low phase 10 clocks, high phase 10 clocks
   task automatic put(input logic b, output logic r);
      hold(2);
      sda_low = !b;
      hold(8);
      scl = 1'b1;
      hold(6);
      r = sda_wire;
      hold(4);
      scl = 1'b0;
   endtask : put
   task automatic start;
      hold(2);
      sda_low = 1'b0;
      hold(8);
      scl = 1'b1;
      hold(10);
      sda_low = 1'b1;
      hold(10);
      scl = 1'b0;
   endtask : start
   task automatic stop;
      hold(2);
      sda_low = 1'b1;
      hold(8);
      scl = 1'b1;
      hold(10);
      sda_low = 1'b0;
      hold(10);
   endtask : stop
   task automatic tx(input logic [7:0] d, output logic nak);
      for (int i = 7; i >= 0; i--) put(d[i], nak);
      put(1'b1, nak);
   endtask : tx
   task automatic rx(input logic last, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         put(1'b1, r);
         d[i] = r;
      end
      put(last, r);
   endtask : rx
   // one 16-bit word, high byte first, no preamble
   task automatic access(input logic [7:0] dev, input logic [4:0] rg, input logic rd,
                         inout logic [15:0] w, output logic nak);
      logic [3:0] n;
      start;
      tx(dev, n[0]);
      tx({3'h0, rg}, n[1]);
      if (rd) begin
         start;
         tx(dev | 8'h01, n[2]);
         rx(1'b0, w[15:8]);
         rx(1'b1, w[7:0]);
         n[3] = 1'b0;
      end else begin
         tx(w[15:8], n[2]);
         tx(w[7:0], n[3]);
      end
      stop;
      nak = |n;
   endtask : access
endmodule : phymb_host_model
`default_nettype wire

/* File: phymb_register_bank_tb.sv */
// self-checking bench for the phy management register bank
// assumes the host model drives the bus and the bench drives the core side
`timescale 1ns/1ps
`default_nettype none
module phymb_register_bank_tb
   import phymb_pkg::*;
;
   localparam logic [3:0] ABIL = 4'h5;
   localparam logic [15:0] ADV_RST = {6'h20, 1'b0, ABIL, 5'h01};
   logic clock, rst, scl, sda_low, link_up, remote_fault, jabber, an_complete;
   logic rx_bit, tx_bit, tx_en, col_in, sda_out, sda_oe, serial_tx_pair, col_ind;
   logic soft_reset, power_down, isolate, loopback, col_test, an_enable, an_restart;
   logic force_duplex, nak;
   logic [1:0] force_speed;
   logic [15:0] adv_word, w;
   wire logic sda_wire;
   wire logic [6:0] outs;
   int num_errors = 0;
   int n_tests = 0;
   // pull-up wire: low when either party pulls it
   assign sda_wire = !(sda_oe && !sda_out) && !sda_low;
   assign outs = {soft_reset, an_enable, force_speed, force_duplex, loopback, col_test};
   phymb_register_bank #(.ADV_ABILITY_RESET(ABIL)) i_phymb_register_bank (.clock(clock),
      .rst(rst), .scl_in(scl), .sda_in(sda_wire), .sda_out(sda_out), .sda_oe(sda_oe),
      .link_up(link_up), .remote_fault(remote_fault), .jabber(jabber),
      .an_complete(an_complete), .rx_bit(rx_bit), .tx_bit(tx_bit), .tx_en(tx_en),
      .col_in(col_in), .serial_tx_pair(serial_tx_pair), .col_ind(col_ind),
      .soft_reset(soft_reset), .power_down(power_down), .isolate(isolate),
      .loopback(loopback), .col_test(col_test), .an_enable(an_enable),
      .an_restart(an_restart), .force_speed(force_speed), .force_duplex(force_duplex),
      .adv_word(adv_word));
   phymb_host_model i_phymb_host_model (.clock(clock), .sda_wire(sda_wire), .scl(scl),
      .sda_low(sda_low));
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp) begin
         num_errors++;
         $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic wr(input logic [4:0] rg, input logic [15:0] d);
      i_phymb_host_model.access(8'hae, rg, 1'b0, d, nak);
      check(16'(nak), 16'h0000);
   endtask : wr
   task automatic rchk(input logic [4:0] rg, input logic [15:0] exp);
      logic [15:0] d;
      d = 16'h0000;
      i_phymb_host_model.access(8'hae, rg, 1'b1, d, nak);
      check(d, exp);
   endtask : rchk
   task automatic finish_test;
      $display("checks %0d errors %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : finish_test
   initial begin
      clock = 1'b0;
      forever #2.5 clock = ~clock;
   end
   initial begin
      #400000;
      num_errors++;
      finish_test;
   end
   initial begin
      rst = 1'b1;
      link_up = 1'b0;
      remote_fault = 1'b0;
      jabber = 1'b0;
      an_complete = 1'b0;
      rx_bit = 1'b0;
      tx_bit = 1'b0;
      tx_en = 1'b0;
      col_in = 1'b0;
      w = 16'h0000;
      repeat (3) @(negedge clock);
      rst = 1'b0;
      i_phymb_host_model.hold(6);
      rchk(REG_CONTROL, 16'h1140);
      rchk(REG_STATUS, 16'h0149);
      rchk(REG_ADVERT, ADV_RST);
      check(16'(outs), 16'h0034);
      check(adv_word, ADV_RST);
      $display("test reset values done");
      for (int p = 0; p < 4; p++) begin
         wr(REG_ADVERT, {4'h8, 2'(p), 10'h000});
         rchk(REG_ADVERT, {4'h8, 2'(p), 10'h001});
      end
      wr(REG_ADVERT, 16'hac00);
      rchk(REG_ADVERT, 16'hac01);
      check(adv_word, ADV_RST);
      wr(REG_CONTROL, 16'h1340);
      check(adv_word, 16'hac01);
      rchk(REG_CONTROL, 16'h1140);
      wr(REG_ADVERT, 16'h84e0);
      link_up = 1'b1;
      an_complete = 1'b1;
      i_phymb_host_model.hold(20);
      link_up = 1'b0;
      remote_fault = 1'b1;
      jabber = 1'b1;
      i_phymb_host_model.hold(20);
      link_up = 1'b1;
      remote_fault = 1'b0;
      jabber = 1'b0;
      i_phymb_host_model.hold(20);
      check(adv_word, 16'h8401);
      rchk(REG_STATUS, 16'h017b);
      rchk(REG_STATUS, 16'h016d);
      an_complete = 1'b0;
      wr(REG_STATUS, 16'h0000);
      rchk(REG_STATUS, 16'h014d);
      $display("test advertisement and status done");
      wr(REG_CONTROL, 16'h2000);
      rchk(REG_CONTROL, 16'h2000);
      check(16'(outs), 16'h0034);
      tx_bit = 1'b1;
      wr(REG_CONTROL, 16'h2c00);
      check(16'({power_down, isolate, serial_tx_pair}), 16'h0006);
      // reset request together with set bits: the reset must still clear power-down, isolate and collision test, keeping speed bit 13
      wr(REG_CONTROL, 16'hac80);
      check(16'(soft_reset), 16'h0001);
      for (int i = 0; i < 300 && soft_reset; i++) @(negedge clock);
      check(16'(outs), 16'h0008);
      check(16'({power_down, isolate}), 16'h0000);
      rchk(REG_CONTROL, 16'h2000);
      $display("test forced mode done");
      wr(REG_CONTROL, 16'h6080);
      rx_bit = 1'b1;
      tx_bit = 1'b0;
      tx_en = 1'b1;
      i_phymb_host_model.hold(3);
      check(16'({serial_tx_pair, col_ind}), 16'h0003);
      rx_bit = 1'b0;
      i_phymb_host_model.hold(3);
      check(16'({serial_tx_pair, col_ind}), 16'h0001);
      wr(REG_CONTROL, 16'h2000);
      tx_bit = 1'b1;
      i_phymb_host_model.hold(3);
      check(16'({serial_tx_pair, col_ind}), 16'h0002);
      tx_en = 1'b0;
      col_in = 1'b1;
      i_phymb_host_model.hold(3);
      check(16'({serial_tx_pair, col_ind}), 16'h0003);
      col_in = 1'b0;
      i_phymb_host_model.access(8'ha0, REG_CONTROL, 1'b0, w, nak);
      check(16'(nak), 16'h0001);
      rchk(REG_CONTROL, 16'h2000);
      $display("test datapath and addressing done");
      finish_test;
   end
endmodule : phymb_register_bank_tb
`default_nettype wire
